// ===== dmct_pkg.sv
/*
  Package for the dynamic memory cycle timing block: widths, timing
  figures and the request/strobe carriers.
  Assumes a single 100 MHz clock shared by every user of the package.
*/
package dmct_pkg;

  // ********************************************************
  // Widths
  // ********************************************************
  localparam int unsigned DMCT_ADDR_W = 32;
  localparam int unsigned DMCT_DATA_W = 36;

  // ********************************************************
  // Timing
  // ********************************************************
  localparam int unsigned DMCT_CLK_PERIOD_NS = 10;
  localparam int unsigned DMCT_PRE_DELAY_NS = 50;
  localparam int unsigned DMCT_PRE_WIDTH_NS = 200;
  localparam int unsigned DMCT_CE_DELAY_NS = 150;
  localparam int unsigned DMCT_CE_READ_NS = 200;
  localparam int unsigned DMCT_CE_WRITE_NS = 400;
  localparam int unsigned DMCT_CNT_W = 8;
  // Least times round up to whole cycles
  localparam logic [DMCT_CNT_W-1:0] DMCT_PRE_ON = DMCT_CNT_W'(
    (DMCT_PRE_DELAY_NS + DMCT_CLK_PERIOD_NS - 1) / DMCT_CLK_PERIOD_NS);
  localparam logic [DMCT_CNT_W-1:0] DMCT_PRE_OFF = DMCT_CNT_W'(
    (DMCT_PRE_DELAY_NS + DMCT_PRE_WIDTH_NS + DMCT_CLK_PERIOD_NS - 1)
    / DMCT_CLK_PERIOD_NS);
  localparam logic [DMCT_CNT_W-1:0] DMCT_CE_ON = DMCT_CNT_W'(
    (DMCT_CE_DELAY_NS + DMCT_CLK_PERIOD_NS - 1) / DMCT_CLK_PERIOD_NS);
  localparam logic [DMCT_CNT_W-1:0] DMCT_CE_OFF_RD = DMCT_CNT_W'(
    (DMCT_CE_DELAY_NS + DMCT_CE_READ_NS + DMCT_CLK_PERIOD_NS - 1)
    / DMCT_CLK_PERIOD_NS);
  localparam logic [DMCT_CNT_W-1:0] DMCT_CE_OFF_WR = DMCT_CNT_W'(
    (DMCT_CE_DELAY_NS + DMCT_CE_WRITE_NS + DMCT_CLK_PERIOD_NS - 1)
    / DMCT_CLK_PERIOD_NS);
  // Write data is presented only in the latter part of the cycle
  localparam logic [DMCT_CNT_W-1:0] DMCT_WR_DATA_AT = DMCT_CE_OFF_RD;
  localparam logic [DMCT_CNT_W-1:0] DMCT_CNT_ONE = DMCT_CNT_W'(1);

  // ********************************************************
  // Carriers
  // ********************************************************
  typedef struct packed {
    logic refresh;
    logic micro_fetch;
    logic memory_access_micro;
    logic console;
    logic write;
  } dmct_req_s;

  typedef struct packed {
    logic chip_precharge_strobe;
    logic chip_enable_strobe;
    logic write_select;
    logic refresh;
  } dmct_strobe_s;

  typedef enum logic [2:0] {
    DMCT_IDLE = 3'b001,
    DMCT_RUN = 3'b010,
    DMCT_DONE = 3'b100
  } dmct_state_e;

endpackage

// ===== dmct_data_reg.sv
/*
  Holding register for the address and write data of one memory cycle.
  Assumes the caller loads it only at the start of a cycle.
*/
`timescale 1ns/10ps
`default_nettype none
module dmct_data_reg (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic srst_i,
  // Load side
  input wire logic load_i,
  input wire logic [dmct_pkg::DMCT_ADDR_W-1:0] addr_i,
  input wire logic [dmct_pkg::DMCT_DATA_W-1:0] wdata_i,
  // Held values
  output logic [dmct_pkg::DMCT_ADDR_W-1:0] addr_o,
  output logic [dmct_pkg::DMCT_DATA_W-1:0] wdata_o
);
  import dmct_pkg::*;

  logic [DMCT_ADDR_W-1:0] addr_d;
  logic [DMCT_DATA_W-1:0] wdata_d;

  always_comb begin
    addr_d = addr_o;
    wdata_d = wdata_o;
    if (load_i) begin
      addr_d = addr_i;
      wdata_d = wdata_i;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      addr_o <= '0;
      wdata_o <= '0;
    end else begin
      addr_o <= addr_d;
      wdata_o <= wdata_d;
    end
  end

endmodule
`default_nettype wire

// ===== dmct_timing.sv
/*
  Dynamic memory cycle timing: starts one cycle per request and walks
  precharge, chip enable and write select toward the storage chips.
  Assumes requests come from logic on mclk_i; read data arrive from the
  storage chips asynchronously and are synchronised here.
*/
// Behaviour
// [R1] Any refresh, micro fetch, memory micro or console access starts a cycle.
// [R2] Write start raised only for write memory micro or console write.
// [R3] Precharge strobe follows cycle start after a delay, before chip enable.
// [R4] Chip enable comes later than precharge and overlaps it.
// [R5] Write select high for write, low for read.
// [R6] Write start stretches chip enable until the write completes.
// [R7] A write reads first; data stored only in the latter part.
// [R8] Refresh has its own line, separate from the other strobes.
// [R9] One line each strobe, 32 address, 36 write and 36 read data.
// [R10] One cycle at a time; no new start before sequence ends.
`timescale 1ns/10ps
`default_nettype none
module dmct_timing (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic srst_i,
  // Processor side
  input wire dmct_pkg::dmct_req_s req_i,
  input wire logic [dmct_pkg::DMCT_ADDR_W-1:0] addr_i,
  input wire logic [dmct_pkg::DMCT_DATA_W-1:0] wdata_i,
  output logic busy_o,
  output logic memory_cycle_start_o,
  output logic write_cycle_start_o,
  output logic done_o,
  output logic [dmct_pkg::DMCT_DATA_W-1:0] rdata_o,
  // Storage chip side
  output dmct_pkg::dmct_strobe_s strobe_o,
  output logic [dmct_pkg::DMCT_ADDR_W-1:0] mem_addr_o,
  output logic [dmct_pkg::DMCT_DATA_W-1:0] mem_wdata_o,
  input wire logic [dmct_pkg::DMCT_DATA_W-1:0] mem_rdata_i
);
  import dmct_pkg::*;

  // ********************************************************
  // Request decode
  // ********************************************************
  logic any_req;
  logic wr_req;
  logic start;
  assign any_req = req_i.refresh | req_i.micro_fetch |
                   req_i.memory_access_micro | req_i.console; // see [R1]
  // Write only meaningful for memory micro or console
  assign wr_req = req_i.write &
                  (req_i.memory_access_micro | req_i.console); // see [R2]

  // ********************************************************
  // Sequencer
  // ********************************************************
  dmct_state_e state_q, state_d;
  logic [DMCT_CNT_W-1:0] cnt_q, cnt_d;
  logic wr_q, wr_d;
  logic ref_q, ref_d;
  logic mstart_q, mstart_d;
  logic wstart_q, wstart_d;
  logic done_q, done_d;
  logic busy_q, busy_d;
  logic [DMCT_CNT_W-1:0] ce_end;

  assign start = (state_q == DMCT_IDLE) && any_req; // see [R10]
  // Write cycle holds enable longer so the read part finishes first
  assign ce_end = wr_q ? DMCT_CE_OFF_WR : DMCT_CE_OFF_RD; // see [R6]

  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    wr_d = wr_q;
    ref_d = ref_q;
    mstart_d = 1'b0;
    wstart_d = 1'b0;
    done_d = 1'b0;
    unique case (state_q)
      DMCT_IDLE: begin
        if (start) begin
          state_d = DMCT_RUN;
          cnt_d = DMCT_CNT_ONE;
          wr_d = wr_req;
          ref_d = req_i.refresh;
          mstart_d = 1'b1; // see [R1]
          wstart_d = wr_req; // see [R2]
        end
      end
      DMCT_RUN: begin
        cnt_d = cnt_q + DMCT_CNT_ONE;
        if (cnt_q == ce_end) begin
          state_d = DMCT_DONE;
        end
      end
      DMCT_DONE: begin
        state_d = DMCT_IDLE;
        wr_d = 1'b0;
        ref_d = 1'b0;
        done_d = 1'b1;
      end
      default: begin
        state_d = DMCT_IDLE;
      end
    endcase
    // Registered so the busy output comes straight from a flop
    busy_d = (state_d != DMCT_IDLE); // see [R10]
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      state_q <= DMCT_IDLE;
      cnt_q <= '0;
      wr_q <= 1'b0;
      ref_q <= 1'b0;
      mstart_q <= 1'b0;
      wstart_q <= 1'b0;
      done_q <= 1'b0;
      busy_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      wr_q <= wr_d;
      ref_q <= ref_d;
      mstart_q <= mstart_d;
      wstart_q <= wstart_d;
      done_q <= done_d;
      busy_q <= busy_d;
    end
  end

  // ********************************************************
  // Strobes
  // ********************************************************
  dmct_strobe_s strobe_q, strobe_d;
  logic run;
  assign run = (state_q == DMCT_RUN);

  always_comb begin
    strobe_d.chip_precharge_strobe = run && (cnt_q >= DMCT_PRE_ON) &&
                                     (cnt_q < DMCT_PRE_OFF); // see [R3]
    strobe_d.chip_enable_strobe = run && (cnt_q >= DMCT_CE_ON) &&
                                  (cnt_q < ce_end); // see [R4] [R6]
    strobe_d.write_select = run && wr_q; // see [R5]
    strobe_d.refresh = run && ref_q; // see [R8]
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      strobe_q <= '0;
    end else begin
      strobe_q <= strobe_d;
    end
  end

  // ********************************************************
  // Address, write data and read capture
  // ********************************************************
  logic [DMCT_ADDR_W-1:0] held_addr;
  logic [DMCT_DATA_W-1:0] held_wdata;
  logic [DMCT_DATA_W-1:0] wdata_out_q, wdata_out_d;
  logic [DMCT_DATA_W-1:0] rd_sync1_q, rd_sync2_q, rdata_q, rdata_d;
  logic [DMCT_ADDR_W-1:0] maddr_q;

  dmct_data_reg u_hold (
    .mclk_i(mclk_i),
    .srst_i(srst_i),
    .load_i(start),
    .addr_i(addr_i),
    .wdata_i(wdata_i),
    .addr_o(held_addr),
    .wdata_o(held_wdata)
  );

  always_comb begin
    // Data driven only late in a write, after the read part
    wdata_out_d = (run && wr_q && cnt_q >= DMCT_WR_DATA_AT) ?
                  held_wdata : '0; // see [R7]
    rdata_d = rdata_q;
    // Read sampled where a read's chip enable ends, on reads and writes alike
    if (run && cnt_q == DMCT_CE_OFF_RD) begin
      rdata_d = rd_sync2_q; // see [R7]
    end
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      wdata_out_q <= '0;
      rd_sync1_q <= '0;
      rd_sync2_q <= '0;
      rdata_q <= '0;
      maddr_q <= '0;
    end else begin
      wdata_out_q <= wdata_out_d;
      rd_sync1_q <= mem_rdata_i;
      rd_sync2_q <= rd_sync1_q;
      rdata_q <= rdata_d;
      maddr_q <= held_addr; // see [R9]
    end
  end

  assign busy_o = busy_q;
  assign memory_cycle_start_o = mstart_q;
  assign write_cycle_start_o = wstart_q;
  assign done_o = done_q;
  assign rdata_o = rdata_q;
  assign strobe_o = strobe_q;
  assign mem_addr_o = maddr_q;
  assign mem_wdata_o = wdata_out_q;

  // ********************************************************
  // Checks
  // ********************************************************
  start_on_req_a: assert property ( // see [R1]
    @(posedge mclk_i) disable iff (srst_i)
    (state_q == DMCT_IDLE && any_req) |=> memory_cycle_start_o)
    else $error("request did not start a cycle");
  write_start_a: assert property ( // see [R2]
    @(posedge mclk_i) disable iff (srst_i)
    write_cycle_start_o |-> memory_cycle_start_o && wr_q)
    else $error("write start without write cycle");
  pre_before_ce_a: assert property ( // see [R3]
    @(posedge mclk_i) disable iff (srst_i)
    $rose(strobe_o.chip_enable_strobe) |->
      strobe_o.chip_precharge_strobe)
    else $error("enable rose without precharge");
  // Precharge turns on after five quiet cycles
  pre_delay_a: assert property ( // see [R3]
    @(posedge mclk_i) disable iff (srst_i)
    memory_cycle_start_o |-> !strobe_o.chip_precharge_strobe [*5]
      ##1 strobe_o.chip_precharge_strobe)
    else $error("precharge delay wrong");
  // Reset in mid-cycle drops both strobes; not an overlap fault
  ce_overlap_a: assert property ( // see [R4]
    @(posedge mclk_i) disable iff (srst_i)
    (!$past(srst_i) && $fell(strobe_o.chip_precharge_strobe)) |->
      strobe_o.chip_enable_strobe)
    else $error("enable and precharge do not overlap");
  ce_read_end_a: assert property ( // see [R4]
    @(posedge mclk_i) disable iff (srst_i)
    (memory_cycle_start_o && !write_cycle_start_o) |->
      ##34 strobe_o.chip_enable_strobe ##1 !strobe_o.chip_enable_strobe)
    else $error("read enable length wrong");
  wsel_level_a: assert property ( // see [R5]
    @(posedge mclk_i) disable iff (srst_i)
    strobe_o.chip_enable_strobe |-> strobe_o.write_select == wr_q)
    else $error("write select wrong");
  // Read part alone would drop enable long before this
  ce_stretch_a: assert property ( // see [R6]
    @(posedge mclk_i) disable iff (srst_i)
    write_cycle_start_o |-> ##54 strobe_o.chip_enable_strobe
      ##1 !strobe_o.chip_enable_strobe)
    else $error("enable not stretched on write");
  late_write_a: assert property ( // see [R7]
    @(posedge mclk_i) disable iff (srst_i)
    memory_cycle_start_o |-> (mem_wdata_o == '0) [*8]
      ##27 (mem_wdata_o == '0))
    else $error("write data driven early");
  one_cycle_a: assert property ( // see [R10]
    @(posedge mclk_i) disable iff (srst_i)
    memory_cycle_start_o |=> !memory_cycle_start_o [*8])
    else $error("overlapping cycle start");

endmodule
`default_nettype wire

// ===== dmct_chip_model.sv
/* Storage chip model: a small word array behind the strobes.
   Assumes strobes and address come from dmct_timing on mclk_i. */
`timescale 1ns/10ps
`default_nettype none
module dmct_chip_model (
  // Clock and strobes
  input wire logic mclk_i,
  input wire dmct_pkg::dmct_strobe_s strobe_i,
  input wire logic [31:0] addr_i,
  input wire logic [35:0] wdata_i,
  // Answers
  output logic [35:0] rdata_o,
  output logic fault_o
);
  import dmct_pkg::*;
  logic [35:0] mem_q [16];
  logic ce_q;
  logic wr_q;
  logic ce;
  assign ce = strobe_i.chip_enable_strobe;
  initial begin
    foreach (mem_q[i]) mem_q[i] = 36'h0;
    rdata_o = 36'h0;
    fault_o = 1'b0;
    ce_q = 1'b0;
    wr_q = 1'b0;
  end
  always @(posedge mclk_i) begin
    ce_q <= ce;
    // Enable must land inside the precharge pulse
    if (ce && !ce_q) begin
      wr_q <= strobe_i.write_select;
      if (!strobe_i.chip_precharge_strobe) begin
        fault_o <= 1'b1;
      end
    end
    // Store only as enable ends, after the read part
    if (!ce && ce_q && wr_q) begin
      mem_q[addr_i[3:0]] <= wdata_i;
    end
    // Released lines wander so stale data cannot pass
    if (ce && !strobe_i.write_select) begin
      rdata_o <= mem_q[addr_i[3:0]];
    end else begin
      rdata_o <= ~rdata_o;
    end
  end
endmodule
`default_nettype wire

// ===== tb_top.sv
/* Self-checking bench for dmct_timing with a chip model.
   Assumes nothing beyond the package; clock made here at 100 MHz. */
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import dmct_pkg::*;
  typedef struct packed {
    dmct_req_s req;
    logic wr;
  } dmct_row_s;
  localparam dmct_row_s ROWS [7] = '{'{5'h10, 1'h0}, '{5'h08, 1'h0},
    '{5'h04, 1'h0}, '{5'h05, 1'h1}, '{5'h02, 1'h0}, '{5'h03, 1'h1},
    '{5'h09, 1'h0}};
  logic mclk_i, srst_i, busy, mstart, wstart, done, fault;
  dmct_req_s req;
  dmct_strobe_s strobe;
  logic [31:0] addr, mem_addr;
  logic [35:0] wdata, rdata, mem_wdata, mem_rdata;
  int bad_count = 0;
  int num_checks = 0;
  int n [8];
  int p0, c0, pl, wd0;
  logic late_ok;
  dmct_timing dut (.mclk_i(mclk_i), .srst_i(srst_i), .req_i(req),
    .addr_i(addr), .wdata_i(wdata), .busy_o(busy),
    .memory_cycle_start_o(mstart), .write_cycle_start_o(wstart),
    .done_o(done), .rdata_o(rdata), .strobe_o(strobe),
    .mem_addr_o(mem_addr), .mem_wdata_o(mem_wdata),
    .mem_rdata_i(mem_rdata));
  dmct_chip_model chips (.mclk_i(mclk_i), .strobe_i(strobe),
    .addr_i(mem_addr), .wdata_i(mem_wdata), .rdata_o(mem_rdata),
    .fault_o(fault));
  initial begin
    mclk_i = 1'b0;
    forever #5 mclk_i = ~mclk_i;
  end
  task automatic chk(input logic [35:0] got, input logic [35:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %0h exp %0h", $time, got, exp);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // One whole cycle; late request lands while busy and must be dropped
  task automatic run_op(input dmct_req_s r, input logic wr,
      input logic [35:0] d, input dmct_req_s late);
    n = '{default: 0};
    p0 = -1;
    c0 = -1;
    pl = -1;
    wd0 = -1;
    req = r;
    addr = {24'h0, d[7:0]};
    wdata = d;
    for (int t = 0; t < 70; t++) begin
      @(posedge mclk_i);
      #1;
      if (t == 0 || t == 20) req = 5'h00;
      if (t == 10) req = late;
      n[0] += (mstart === 1'b1);
      n[1] += (wstart === 1'b1);
      n[2] += (done === 1'b1);
      n[3] += (strobe.chip_precharge_strobe === 1'b1);
      n[4] += (strobe.chip_enable_strobe === 1'b1);
      n[5] += (strobe.write_select === 1'b1);
      n[6] += (strobe.refresh === 1'b1);
      n[7] += (strobe.chip_enable_strobe === 1'b1 && mem_addr !== addr);
      if (strobe.chip_precharge_strobe === 1'b1) pl = t;
      if (p0 < 0 && pl >= 0) p0 = t;
      if (c0 < 0 && strobe.chip_enable_strobe === 1'b1) c0 = t;
      if (wd0 < 0 && mem_wdata !== 36'h0) wd0 = t;
    end
    late_ok = wr ? (wd0 >= c0 + int'(DMCT_CE_OFF_RD - DMCT_CE_ON)) :
              (wd0 < 0);
    chk(n[0], 1);
    chk(n[1], wr);
    chk(n[2], 1);
    chk(busy, 1'h0);
    chk(n[3], DMCT_PRE_OFF - DMCT_PRE_ON);
    chk(c0 - p0, DMCT_CE_ON - DMCT_PRE_ON);
    chk(c0 <= pl, 1'h1);
    chk(n[4], (wr ? DMCT_CE_OFF_WR : DMCT_CE_OFF_RD) - DMCT_CE_ON);
    chk(n[5] != 0, wr);
    chk(n[6] != 0, r.refresh);
    chk(n[7], 0);
    chk(late_ok, 1'h1);
  endtask
  initial begin
    srst_i = 1'b1;
    req = 5'h00;
    addr = 32'h0;
    wdata = 36'h0;
    repeat (6) @(posedge mclk_i);
    #1;
    chk({busy, mstart, wstart, done, strobe}, 36'h0);
    srst_i = 1'b0;
    foreach (ROWS[i])
      run_op(ROWS[i].req, ROWS[i].wr, 36'hA5A5A5A50 + i, 5'h00);
    // Write aborted by reset in mid-cycle
    req = 5'h05;
    addr = 32'h7;
    @(posedge mclk_i);
    #1;
    req = 5'h00;
    repeat (19) @(posedge mclk_i);
    #1;
    srst_i = 1'b1;
    @(posedge mclk_i);
    #1;
    srst_i = 1'b0;
    chk({busy, mstart, wstart, done, strobe}, 36'h0);
    run_op(5'h04, 1'h0, 36'hA5A5A5A53, 5'h03);
    chk(rdata, 36'hA5A5A5A53);
    chk(fault, 1'h0);
    close_out();
  end
  // Whole run needs about 590 cycles
  initial begin
    #20000;
    bad_count++;
    close_out();
  end
endmodule
`default_nettype wire
